/* shared/sepp_defines.vh */
// Constants of the serial EEPROM slave port
`ifndef SEPP_DEFINES_VH
`define SEPP_DEFINES_VH

`define SEPP_OP_ENABLE_MODIFY 8'h06
`define SEPP_OP_DISABLE_MODIFY 8'h04
`define SEPP_OP_READ_STATE 8'h05
`define SEPP_OP_LOAD_STATE 8'h01
`define SEPP_OP_READ_ARRAY 8'h03
`define SEPP_OP_WRITE_ARRAY 8'h02

`define SEPP_ADDR_W 15
`define SEPP_MEM_DEPTH 32768
`define SEPP_PAGE_BYTES 64
`define SEPP_PAGE_IDX_W 6

`define SEPP_STATE_BUSY 0
`define SEPP_STATE_WEL 1
`define SEPP_STATE_PSLO 2
`define SEPP_STATE_PSHI 3
`define SEPP_STATE_WDIS 7

`define SEPP_CLK_HZ 40000000
`define SEPP_PROG_TIME_MS 10
`define SEPP_PROG_CYCLES ((`SEPP_PROG_TIME_MS * `SEPP_CLK_HZ) / 1000)
`endif

/* logic/sepp_eeprom_port.v */
// Serial EEPROM slave port with array, state register and write timer
// Summary of operation
// [RULE1] Serial output changes after each falling serial clock edge.
// [RULE2] Input bits are captured on each rising serial clock edge.
// [RULE3] Select high deselects; serial output released to high impedance.
// [RULE4] Deselected and idle means standby; running write cycle still completes.
// [RULE5] After reset, only a falling select edge can select the device.
// [RULE6] Pause suspends the transfer without deselecting; it resumes afterwards.
// [RULE7] During pause output released; serial input and clock ignored.
// [RULE8] Master enters a pause only while select is low.
// [RULE9] Write protect freezes the two protect-size bits. The code freezes them, and wdis, only while wdis is set.
// [RULE10] Master keeps write protect stable during every write.
// [RULE11] Opcodes, address and data bytes arrive most significant bit first.
// [RULE12] First bit taken on first rising clock after select falls.
// [RULE13] Read data leaves MSB first from first falling edge after opcode.
// [RULE14] Master uses mode 0,0 or 1,1 only.
// [RULE15] Idle clock rests low in mode 0, high in mode 1.
// [RULE16] While reset is asserted nothing operates and no instruction is answered.
// [RULE17] Master keeps select high during power-down.
// [RULE18] Array holds 32768 bytes addressed serially.
// [RULE19] Single byte writes and page writes of up to 64 bytes.
// [RULE20] Self-timed programming completes within its programming time.
// [RULE21] Every instruction starts with one of six eight-bit opcodes.
// [RULE22] Unknown opcode deselects the device for the rest of the frame.
// [RULE23] Pause starts or ends only while the serial clock is low.
// [RULE24] Modifying instruction executes when select rises after a complete byte.
// [RULE25] Bit counter and shift register hold their values through a pause.
// [RULE26] Two address bytes give a 15-bit address, top bit ignored.
`timescale 1ns/1ps
`include "sepp_defines.vh"

module sepp_eeprom_port #(
    parameter PROG_CYCLES = `SEPP_PROG_CYCLES
) (
    // System
    input wire sys_clk,
    input wire rst_n,
    // Serial pins
    input wire serialClk,
    input wire serialIn,
    input wire selectN,
    input wire pauseN,
    input wire writeProtectN,
    output reg serialOut,
    output reg serialOutEn,
    // Status
    output wire busy
);
    localparam ST_IDLE = 5'h01;
    localparam ST_OPC = 5'h02;
    localparam ST_ADDR = 5'h04;
    localparam ST_DATA = 5'h08;
    localparam ST_SKIP = 5'h10;

    reg [2:0] clkSync, selSync, dinSync, pauseSync, wpSync;
    reg [4:0] state;
    reg armed;
    reg paused;
    reg [2:0] bitCnt;
    reg [7:0] shiftIn;
    reg [7:0] opcode;
    reg [4:0] addrBits;
    reg [15:0] addr;
    reg [7:0] outByte;
    reg firstOut;
    reg wel, protHi, protLo, wdis;
    reg [7:0] mem [0:`SEPP_MEM_DEPTH-1];
    reg [7:0] page [0:`SEPP_PAGE_BYTES-1];
    reg [`SEPP_PAGE_IDX_W:0] pageCnt;
    reg [`SEPP_PAGE_IDX_W-1:0] pageStart;
    reg [`SEPP_ADDR_W-1:0] pageBase;
    reg [7:0] newState;
    reg progArray, progState;
    reg [23:0] progTimer;
    reg [`SEPP_PAGE_IDX_W:0] commitIdx;

    wire sclk = clkSync[1];
    wire sclkRise = clkSync[1] & ~clkSync[2];
    wire sclkFall = ~clkSync[1] & clkSync[2];
    wire sel = ~selSync[1];
    wire selFall = ~selSync[1] & selSync[2];
    wire selRise = selSync[1] & ~selSync[2];
    wire din = dinSync[1];
    wire wp = ~wpSync[1];
    wire active = sel & armed & ~paused;
    wire [7:0] nextByte = {shiftIn[6:0], din};
    wire [7:0] stateByte = {wdis, 3'h0, protHi, protLo, wel, busy};

    assign busy = progArray | progState;

    function isKnownOp;
        input [7:0] op;
        begin
            isKnownOp = (op == `SEPP_OP_ENABLE_MODIFY) || (op == `SEPP_OP_DISABLE_MODIFY) ||
                        (op == `SEPP_OP_READ_STATE) || (op == `SEPP_OP_LOAD_STATE) ||
                        (op == `SEPP_OP_READ_ARRAY) || (op == `SEPP_OP_WRITE_ARRAY);
        end
    endfunction

    // Protected area check from the protect-size bits
    function isProtected;
        input [`SEPP_ADDR_W-1:0] a;
        begin
            case ({protHi, protLo})
                2'b01: isProtected = (a[14:13] == 2'b11);
                2'b10: isProtected = a[14];
                2'b11: isProtected = 1'b1;
                default: isProtected = 1'b0;
            endcase
        end
    endfunction

    // Two-stage synchronisers; stage 2 feeds edge detect
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            clkSync <= 3'h0;
            // Reset as selected: a pin held low through reset makes no false select edge
            selSync <= 3'h0; // [RULE5]
            dinSync <= 3'h0;
            pauseSync <= 3'h7;
            wpSync <= 3'h7;
        end else begin
            clkSync <= {clkSync[1:0], serialClk};
            selSync <= {selSync[1:0], selectN};
            dinSync <= {dinSync[1:0], serialIn};
            pauseSync <= {pauseSync[1:0], pauseN};
            wpSync <= {wpSync[1:0], writeProtectN};
        end
    end

    // Pause enters and leaves while clock low; deselect clears it at any clock level
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            paused <= 1'b0; // [RULE16]
        end else if (!sel) begin
            paused <= 1'b0;
        end else if (!sclk) begin
            paused <= ~pauseSync[1]; // [RULE23] [RULE6] [RULE8]
        end
    end

    // Frame engine
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE; // [RULE16]
            armed <= 1'b0; // [RULE5]
            bitCnt <= 3'h0;
            shiftIn <= 8'h00;
            opcode <= 8'h00;
            addrBits <= 5'h0;
            addr <= 16'h0000;
            outByte <= 8'h00;
            firstOut <= 1'b0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
            wel <= 1'b0;
            protHi <= 1'b0;
            protLo <= 1'b0;
            wdis <= 1'b0;
            pageCnt <= 7'h0;
            pageStart <= 6'h0;
            pageBase <= 15'h0;
            newState <= 8'h00;
            progArray <= 1'b0;
            progState <= 1'b0;
            progTimer <= 24'h0;
            commitIdx <= 7'h0;
        end else begin
            // Self-timed programming continues regardless of select
            if (busy) begin
                if (progArray && commitIdx < pageCnt) begin
                    mem[{pageBase[14:6], pageStart + commitIdx[5:0]}] <=
                        page[pageStart + commitIdx[5:0]]; // [RULE19] [RULE4]
                    commitIdx <= commitIdx + 7'h1;
                end
                if (progTimer >= PROG_CYCLES[23:0] - 24'h1) begin
                    if (progState) begin
                        protHi <= newState[`SEPP_STATE_PSHI];
                        protLo <= newState[`SEPP_STATE_PSLO];
                        wdis <= newState[`SEPP_STATE_WDIS];
                    end
                    progArray <= 1'b0; // [RULE20]
                    progState <= 1'b0;
                    progTimer <= 24'h0;
                end else begin
                    progTimer <= progTimer + 24'h1;
                end
            end
            if (selFall) begin
                armed <= 1'b1; // [RULE5]
                state <= ST_OPC;
                bitCnt <= 3'h0; // [RULE12]
                addrBits <= 5'h0;
                pageCnt <= 7'h0;
                firstOut <= 1'b0;
            end
            if (!sel) begin
                serialOutEn <= 1'b0; // [RULE3]
                state <= ST_IDLE;
            end else if (paused) begin
                serialOutEn <= 1'b0; // [RULE7] [RULE25]
            end else if (active && state != ST_IDLE) begin
                serialOutEn <= firstOut;
                if (sclkRise && state != ST_SKIP) begin
                    shiftIn <= nextByte; // [RULE2] [RULE11]
                    bitCnt <= bitCnt + 3'h1;
                    if (bitCnt == 3'h7) begin
                        case (state)
                            ST_OPC: begin
                                opcode <= nextByte;
                                if (!isKnownOp(nextByte)) begin
                                    state <= ST_SKIP; // [RULE22]
                                end else if (nextByte == `SEPP_OP_READ_ARRAY ||
                                             nextByte == `SEPP_OP_WRITE_ARRAY) begin
                                    state <= ST_ADDR; // [RULE21]
                                end else begin
                                    state <= ST_DATA;
                                    if (nextByte == `SEPP_OP_READ_STATE) begin
                                        outByte <= stateByte;
                                        firstOut <= 1'b1;
                                    end
                                end
                            end
                            ST_ADDR: begin
                                addr <= {addr[7:0], nextByte};
                                if (addrBits == 5'h8) begin
                                    state <= ST_DATA;
                                    pageBase <= {addr[6:0], nextByte}; // [RULE26]
                                    pageStart <= nextByte[5:0];
                                    if (opcode == `SEPP_OP_READ_ARRAY) begin
                                        outByte <= mem[{addr[6:0], nextByte}]; // [RULE18]
                                        addr <= {1'b0, addr[6:0], nextByte} + 16'h1;
                                        firstOut <= 1'b1;
                                    end
                                end
                                addrBits <= addrBits + 5'h8;
                            end
                            ST_DATA: begin
                                if (opcode == `SEPP_OP_WRITE_ARRAY && !busy) begin
                                    page[pageStart + pageCnt[5:0]] <= nextByte;
                                    if (pageCnt != 7'h40)
                                        pageCnt <= pageCnt + 7'h1; // [RULE19]
                                end else if (opcode == `SEPP_OP_LOAD_STATE) begin
                                    newState <= nextByte;
                                    pageCnt <= 7'h1;
                                end else if (opcode == `SEPP_OP_READ_ARRAY) begin
                                    outByte <= mem[addr[14:0]];
                                    addr <= {1'b0, addr[14:0] + 15'h1};
                                end else if (opcode == `SEPP_OP_READ_STATE) begin
                                    outByte <= stateByte;
                                end
                            end
                            default: state <= state;
                        endcase
                    end
                end
                if (sclkFall && firstOut) begin
                    serialOut <= outByte[~bitCnt]; // [RULE1] [RULE13]
                    serialOutEn <= 1'b1;
                end
            end else begin
                serialOutEn <= 1'b0;
            end
            // Execution on select rising at a byte boundary
            if (selRise && armed && bitCnt == 3'h0 && !busy && state != ST_SKIP) begin // [RULE24]
                if (opcode == `SEPP_OP_ENABLE_MODIFY && state == ST_DATA) begin
                    wel <= 1'b1;
                end else if (opcode == `SEPP_OP_DISABLE_MODIFY && state == ST_DATA) begin
                    wel <= 1'b0;
                end else if (wel && pageCnt != 7'h0 && state == ST_DATA) begin
                    if (opcode == `SEPP_OP_LOAD_STATE) begin
                        wel <= 1'b0;
                        if (!(wdis && wp)) begin
                            progState <= 1'b1; // [RULE9]
                        end
                    end else if (opcode == `SEPP_OP_WRITE_ARRAY) begin
                        wel <= 1'b0;
                        if (!isProtected(pageBase)) begin
                            progArray <= 1'b1;
                            commitIdx <= 7'h0;
                        end
                    end
                end
            end
        end
    end
endmodule

/* test/sepp_eeprom_port_properties.sv */
// Port assertions for the EEPROM serial port
`timescale 1ns/1ps
module sepp_eeprom_port_properties #(
    parameter PROG_CYCLES = 200
) (
    // System
    input wire sys_clk,
    input wire rst_n,
    // Serial pins
    input wire serialClk,
    input wire serialIn,
    input wire selectN,
    input wire pauseN,
    input wire writeProtectN,
    input wire serialOut,
    input wire serialOutEn,
    input wire busy
);
    int busyLen;
    always @(posedge sys_clk) begin
        if (!rst_n || !busy) busyLen <= 0;
        else busyLen <= busyLen + 1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence selHigh;
        selectN [*5];
    endsequence
    sequence pauseLow;
        (!pauseN && !serialClk && !selectN) [*5];
    endsequence
    rst_quiet_a: assert property (
        $rose(rst_n) |-> !serialOutEn && !busy) else $error("outputs active after reset");
    desel_float_a: assert property (
        selHigh |-> !serialOutEn) else $error("output driven while deselected");
    pause_float_a: assert property (
        pauseLow |-> !serialOutEn) else $error("output driven during pause");
    out_steady_a: assert property (
        (serialClk && serialOutEn) [*3] |=> $stable(serialOut)) else $error("output moved in high clock");
    en_select_a: assert property (
        $rose(serialOutEn) |-> !selectN && pauseN) else $error("output enabled when not selected");
    busy_start_a: assert property (
        $rose(busy) |-> selectN) else $error("program cycle began while selected");
    busy_max_a: assert property (
        busyLen <= PROG_CYCLES + 2) else $error("program cycle too long");
    busy_min_a: assert property (
        $fell(busy) |-> busyLen >= PROG_CYCLES - 1) else $error("program cycle cut short");
endmodule

/* test/sepp_spi_master.sv */
// Behavioural serial bus master
`timescale 1ns/1ps
module sepp_spi_master (
    // Clock
    input wire logic sys_clk,
    // Bus
    output logic serialClk,
    output logic serialIn,
    output logic selectN,
    output logic pauseN,
    output logic writeProtectN,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    logic cpol = 1'b0;
    initial begin
        serialClk = 1'b0;
        serialIn = 1'b0;
        selectN = 1'b0; // Low through reset to probe arming
        pauseN = 1'b1;
        writeProtectN = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic mode(input logic pol);
        cpol = pol;
    endtask
    task automatic clk(input logic v);
        serialClk = v;
    endtask
    task automatic pause(input logic on);
        pauseN = !on;
    endtask
    task automatic protect(input logic on);
        writeProtectN = !on;
    endtask
    // Low half, rise, sample mid high half
    task automatic xbit(input logic b, output logic r);
        serialClk = 1'b0;
        serialIn = b;
        tick(4);
        serialClk = 1'b1;
        tick(2);
        // Released line reads inverted, so a missing drive shows up
        r = serialOutEn ? serialOut : ~serialOut;
        tick(2);
    endtask
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) xbit(tx[i], rx[i]);
    endtask
    // Clock reaches its idle level before select falls
    task automatic frame(input logic on);
        tick(2);
        if (on) serialClk = cpol;
        tick(2);
        selectN = !on;
        tick(2);
        serialClk = cpol;
        serialIn = ~serialIn;
        tick(2);
    endtask
endmodule

/* test/serial_eeprom_spi_slave_port_bench.sv */
// Self-checking bench for the EEPROM serial port
`timescale 1ns/1ps
`include "sepp_defines.vh"
module serial_eeprom_spi_slave_port_bench;
    localparam int PROG = 200;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire serialClk, serialIn, selectN, pauseN, writeProtectN, serialOut, serialOutEn, busy;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] rx;
    always #12.5 sys_clk = ~sys_clk;
    sepp_eeprom_port #(.PROG_CYCLES(PROG)) u_sepp_eeprom_port (.sys_clk(sys_clk), .rst_n(rst_n),
        .serialClk(serialClk), .serialIn(serialIn), .selectN(selectN), .pauseN(pauseN),
        .writeProtectN(writeProtectN), .serialOut(serialOut), .serialOutEn(serialOutEn), .busy(busy));
    sepp_spi_master u_sepp_spi_master (.sys_clk(sys_clk), .serialClk(serialClk), .serialIn(serialIn),
        .selectN(selectN), .pauseN(pauseN), .writeProtectN(writeProtectN), .serialOut(serialOut),
        .serialOutEn(serialOutEn));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        u_sepp_spi_master.xbyte(b, rx);
    endtask
    task automatic sel(input logic on);
        u_sepp_spi_master.frame(on);
    endtask
    task automatic cmd(input logic [7:0] op);
        sel(1);
        send(op);
        sel(0);
    endtask
    task automatic rdstat;
        sel(1);
        send(`SEPP_OP_READ_STATE);
        send(8'h00);
        sel(0);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        check("busy", 8'h00, {7'h00, busy});
        if (n == 1000) wrap_up();
    endtask
    task automatic t_arm;
        send(`SEPP_OP_READ_STATE);
        send(8'h00);
        check("unarmed out", 8'hFF, rx);
        check("unarmed enable", 8'h00, {7'h00, serialOutEn});
        sel(0);
    endtask
    task automatic t_opcodes;
        sel(1);
        send(8'hFF);
        send(`SEPP_OP_ENABLE_MODIFY);
        sel(0);
        rdstat();
        check("after bad op", 8'h00, rx);
        cmd(`SEPP_OP_ENABLE_MODIFY);
        rdstat();
        check("after enable", 8'h02, rx);
        cmd(`SEPP_OP_DISABLE_MODIFY);
        rdstat();
        check("after disable", 8'h00, rx);
    endtask
    task automatic t_page;
        cmd(`SEPP_OP_ENABLE_MODIFY);
        sel(1);
        send(`SEPP_OP_WRITE_ARRAY);
        send(8'hFF);
        send(8'hFE);
        send(8'hA5);
        send(8'h3C);
        send(8'h96);
        sel(0);
        rdstat();
        check("busy bit", 8'h01, rx & 8'h01);
        wait_idle();
        sel(1);
        send(`SEPP_OP_WRITE_ARRAY);
        send(8'h7F);
        send(8'hFE);
        send(8'h00);
        sel(0);
        sel(1);
        send(`SEPP_OP_READ_ARRAY);
        send(8'h7F);
        send(8'hFE);
        send(8'h00);
        check("byte 7FFE", 8'hA5, rx);
        send(8'h00);
        check("byte 7FFF", 8'h3C, rx);
        sel(0);
        sel(1);
        send(`SEPP_OP_READ_ARRAY);
        send(8'h7F);
        send(8'hC0);
        send(8'h00);
        check("wrapped byte", 8'h96, rx);
        sel(0);
    endtask
    task automatic t_pause;
        logic [7:0] got;
        sel(1);
        send(`SEPP_OP_READ_ARRAY);
        send(8'h7F);
        send(8'hFE);
        for (int i = 7; i >= 4; i--) u_sepp_spi_master.xbit(1'b0, got[i]);
        u_sepp_spi_master.clk(1'b0);
        u_sepp_spi_master.tick(4);
        u_sepp_spi_master.pause(1'b1);
        u_sepp_spi_master.tick(6);
        check("enable in pause", 8'h00, {7'h00, serialOutEn});
        u_sepp_spi_master.clk(1'b1);
        u_sepp_spi_master.tick(4);
        u_sepp_spi_master.clk(1'b0);
        u_sepp_spi_master.tick(4);
        u_sepp_spi_master.pause(1'b0);
        u_sepp_spi_master.tick(4);
        for (int i = 3; i >= 0; i--) u_sepp_spi_master.xbit(1'b0, got[i]);
        check("paused byte", 8'hA5, got);
        sel(0);
    endtask
    task automatic load(input logic [7:0] v);
        cmd(`SEPP_OP_ENABLE_MODIFY);
        sel(1);
        send(`SEPP_OP_LOAD_STATE);
        send(v);
        sel(0);
        wait_idle();
    endtask
    task automatic t_protect;
        u_sepp_spi_master.mode(1'b1);
        load(8'h8C);
        rdstat();
        check("state set", 8'h8C, rx);
        u_sepp_spi_master.protect(1'b1);
        load(8'h00);
        rdstat();
        check("state frozen", 8'h8C, rx & 8'h8C);
        u_sepp_spi_master.protect(1'b0);
        load(8'h00);
        rdstat();
        check("state cleared", 8'h00, rx);
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        u_sepp_spi_master.tick(4);
        t_arm();
        t_opcodes();
        t_page();
        t_pause();
        t_protect();
        check("select at end", 8'h01, {7'h00, selectN});
        wrap_up();
    end
endmodule
bind sepp_eeprom_port sepp_eeprom_port_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.sys_clk(sys_clk),
    .rst_n(rst_n), .serialClk(serialClk), .serialIn(serialIn), .selectN(selectN), .pauseN(pauseN),
    .writeProtectN(writeProtectN), .serialOut(serialOut), .serialOutEn(serialOutEn), .busy(busy));
